// file: rtl/fpwc_defines.svh
// Constants for the flash program write control block
`ifndef FPWC_DEFINES_SVH
`define FPWC_DEFINES_SVH

`define FPWC_ADDR_W 2
`define FPWC_DATA_W 8

`define FPWC_ADDR_CTL 2'h0
`define FPWC_ADDR_UNLOCK 2'h1
`define FPWC_ADDR_STS 2'h2
`define FPWC_ADDR_MSK 2'h3

`define FPWC_CTL_START 1
`define FPWC_CTL_PERMIT 2
`define FPWC_CTL_FAULT 3
`define FPWC_CTL_ERASE 4

`define FPWC_STS_DONE 0
`define FPWC_STS_REFUSED 1
`define FPWC_STS_W 2

`define FPWC_UNLOCK_KEY1 8'h55
`define FPWC_UNLOCK_KEY2 8'haa

`define FPWC_CLK_PERIOD_NS 20
`define FPWC_WRITE_TIME_NS 10000
`define FPWC_ERASE_TIME_NS 40000
`define FPWC_TMR_W 12

`endif

// file: rtl/fpwc_pkg.sv
// Types for the flash program write control block
package fpwc_pkg;
    typedef enum logic [1:0] {
        LK_IDLE,
        LK_GOT_KEY1,
        LK_ARMED
    } fpwc_lock_t;
    typedef enum logic {
        OP_IDLE,
        OP_BUSY
    } fpwc_op_t;
endpackage

// file: rtl/fpwc_prog_timer.sv
// Programming timer: counts out one erase or write operation
`timescale 1ns/10ps
`default_nettype none
module fpwc_prog_timer
    import fpwc_pkg::*;
#(
    parameter int CNT_W = 12
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [CNT_W-1:0] i_len,
    output logic o_busy,
    output logic o_done
);
    logic [CNT_W-1:0] cnt_ff;
    logic busy_ff;
    wire expire = busy_ff && (cnt_ff == '0);

    if (CNT_W < 1)
    begin : g_bad_cnt_w
        $error("CNT_W must be at least 1");
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
        end
        else if (i_start && !busy_ff)
        begin
            cnt_ff <= i_len - 1'b1;
            busy_ff <= 1'b1;
        end
        else if (expire)
        begin
            busy_ff <= 1'b0;
        end
        else if (busy_ff)
        begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    assign o_busy = busy_ff;
    assign o_done = expire;
endmodule // fpwc_prog_timer
`default_nettype wire

// file: rtl/fpwc_top.sv
// Flash program write control: control register, unlock port, timer, status
// Contract
// - Unlock port stores nothing, serves only unlock sequences, always reads zero.
// - Erase select set makes the next start an erase; code uses the erase bit of the start write itself.
// - Erase select clear makes a start a write only, never erase.
// - Writes need program permit set; power-up clears program permit.
// - Fault flag sets on start, clears when timer expires and op completes.
// - Software can only set start; hardware clears it on completion.
// - Fault flag stays set after reset-cut or improper write.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "fpwc_defines.svh"
module fpwc_top
    import fpwc_pkg::*;
#(
    parameter int WRITE_TIME_NS = `FPWC_WRITE_TIME_NS,
    parameter int ERASE_TIME_NS = `FPWC_ERASE_TIME_NS,
    parameter int TMR_W = `FPWC_TMR_W
)
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_npor,
    input wire logic [`FPWC_ADDR_W-1:0] i_addr,
    input wire logic [`FPWC_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`FPWC_DATA_W-1:0] o_rdata,
    output logic o_flash_write,
    output logic o_flash_erase,
    output logic o_busy,
    output logic o_irq
);
    localparam int WRITE_CYC_I = (WRITE_TIME_NS + `FPWC_CLK_PERIOD_NS - 1) / `FPWC_CLK_PERIOD_NS;
    localparam int ERASE_CYC_I = (ERASE_TIME_NS + `FPWC_CLK_PERIOD_NS - 1) / `FPWC_CLK_PERIOD_NS;
    localparam int WRITE_CYC = (WRITE_CYC_I < 1) ? 1 : WRITE_CYC_I;
    localparam int ERASE_CYC = (ERASE_CYC_I < 1) ? 1 : ERASE_CYC_I;
    localparam logic [TMR_W-1:0] WRITE_LEN = WRITE_CYC[TMR_W-1:0];
    localparam logic [TMR_W-1:0] ERASE_LEN = ERASE_CYC[TMR_W-1:0];

    // Longest operation must fit the timer
    if (WRITE_CYC >= (1 << TMR_W) || ERASE_CYC >= (1 << TMR_W))
    begin : g_tmr_too_narrow
        $error("Programming time does not fit the timer width");
    end

    // Power-up clears everything; a plain reset spares the fault flag
    wire rst_n = i_nrst & i_npor;

    logic permit_ff;
    logic nxt_permit;
    logic erase_sel_ff;
    logic nxt_erase_sel;
    logic start_ff;
    logic nxt_start;
    logic fault_ff;
    logic nxt_fault;
    logic op_erase_ff;
    logic nxt_op_erase;
    fpwc_op_t op_ff;
    fpwc_op_t nxt_op;
    fpwc_lock_t lock_ff;
    fpwc_lock_t nxt_lock;
    logic [`FPWC_STS_W-1:0] sts_ff;
    logic [`FPWC_STS_W-1:0] nxt_sts;
    logic [`FPWC_STS_W-1:0] msk_ff;
    logic [`FPWC_STS_W-1:0] nxt_msk;
    logic [`FPWC_DATA_W-1:0] rdata_ff;
    logic [`FPWC_DATA_W-1:0] nxt_rdata;
    logic tmr_done;

    wire wr_ctl = i_wr && (i_addr == `FPWC_ADDR_CTL);
    wire wr_unlock = i_wr && (i_addr == `FPWC_ADDR_UNLOCK);
    wire wr_sts = i_wr && (i_addr == `FPWC_ADDR_STS);
    wire wr_msk = i_wr && (i_addr == `FPWC_ADDR_MSK);
    wire start_req = wr_ctl && i_wdata[`FPWC_CTL_START] && !start_ff;
    wire start_go = start_req && permit_ff && (lock_ff == LK_ARMED) && (op_ff == OP_IDLE);
    wire start_refused = start_req && !start_go;
    wire op_done = (op_ff == OP_BUSY) && tmr_done;

    wire [TMR_W-1:0] op_len = i_wdata[`FPWC_CTL_ERASE] ? ERASE_LEN : WRITE_LEN;

    fpwc_prog_timer #(
        .CNT_W(TMR_W)
    ) u_timer (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n),
        .i_start(start_go),
        .i_len(op_len),
        .o_busy(),
        .o_done(tmr_done)
    );

    // Control register fields
    always_comb
    begin
        nxt_permit = permit_ff;
        nxt_erase_sel = erase_sel_ff;
        if (wr_ctl)
        begin
            nxt_permit = i_wdata[`FPWC_CTL_PERMIT];
            nxt_erase_sel = i_wdata[`FPWC_CTL_ERASE];
        end
    end

    // start set only, cleared on completion
    always_comb
    begin
        nxt_start = start_ff;
        if (start_go)
        begin
            nxt_start = 1'b1;
        end
        else if (op_done)
        begin
            nxt_start = 1'b0;
        end
    end

    // fault set on start, cleared on completion
    always_comb
    begin
        nxt_fault = fault_ff;
        if (start_req)
        begin
            nxt_fault = 1'b1;
        end
        else if (op_done)
        begin
            nxt_fault = 1'b0;
        end
    end

    always_comb
    begin
        nxt_op = op_ff;
        nxt_op_erase = op_erase_ff;
        unique case (op_ff)
            OP_IDLE:
            begin
                if (start_go)
                begin
                    nxt_op = OP_BUSY;
                    nxt_op_erase = i_wdata[`FPWC_CTL_ERASE];
                end
            end
            OP_BUSY:
            begin
                if (op_done)
                begin
                    nxt_op = OP_IDLE;
                    nxt_op_erase = 1'b0;
                end
            end
        endcase
    end

    always_comb
    begin
        nxt_lock = lock_ff;
        unique case (lock_ff)
            LK_IDLE:
            begin
                if (wr_unlock && i_wdata == `FPWC_UNLOCK_KEY1)
                begin
                    nxt_lock = LK_GOT_KEY1;
                end
            end
            LK_GOT_KEY1:
            begin
                if (wr_unlock && i_wdata == `FPWC_UNLOCK_KEY2)
                begin
                    nxt_lock = LK_ARMED;
                end
                else if (i_wr)
                begin
                    nxt_lock = LK_IDLE;
                end
            end
            LK_ARMED:
            begin
                if (start_req || wr_unlock)
                begin
                    nxt_lock = LK_IDLE;
                end
            end
            default:
            begin
                nxt_lock = LK_IDLE;
            end
        endcase
    end

    // Sticky status, write one to clear; a new event wins
    always_comb
    begin
        nxt_sts = sts_ff;
        if (wr_sts)
        begin
            nxt_sts = sts_ff & ~i_wdata[`FPWC_STS_W-1:0];
        end
        if (op_done)
        begin
            nxt_sts[`FPWC_STS_DONE] = 1'b1;
        end
        if (start_refused)
        begin
            nxt_sts[`FPWC_STS_REFUSED] = 1'b1;
        end
        nxt_msk = wr_msk ? i_wdata[`FPWC_STS_W-1:0] : msk_ff;
    end

    wire [`FPWC_DATA_W-1:0] ctl_view = {{(`FPWC_DATA_W-5){1'b0}}, erase_sel_ff, fault_ff,
                                        permit_ff, start_ff, 1'b0};
    wire [`FPWC_DATA_W-1:0] sts_view = {{(`FPWC_DATA_W-`FPWC_STS_W){1'b0}}, sts_ff};
    wire [`FPWC_DATA_W-1:0] msk_view = {{(`FPWC_DATA_W-`FPWC_STS_W){1'b0}}, msk_ff};

    always_comb
    begin
        nxt_rdata = '0;
        if (i_rd)
        begin
            unique case (i_addr)
                `FPWC_ADDR_CTL: nxt_rdata = ctl_view;
                `FPWC_ADDR_UNLOCK: nxt_rdata = '0;
                `FPWC_ADDR_STS: nxt_rdata = sts_view;
                `FPWC_ADDR_MSK: nxt_rdata = msk_view;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            permit_ff <= 1'b0;
            erase_sel_ff <= 1'b0;
            start_ff <= 1'b0;
            op_ff <= OP_IDLE;
            op_erase_ff <= 1'b0;
            lock_ff <= LK_IDLE;
        end
        else
        begin
            permit_ff <= nxt_permit;
            erase_sel_ff <= nxt_erase_sel;
            start_ff <= nxt_start;
            op_ff <= nxt_op;
            op_erase_ff <= nxt_op_erase;
            lock_ff <= nxt_lock;
        end
    end

    // fault survives a plain reset; power-up clears it, as does completion
    always_ff @(posedge i_clk_sys or negedge i_npor)
    begin
        if (!i_npor)
        begin
            fault_ff <= 1'b0;
        end
        else if (i_nrst)
        begin
            fault_ff <= nxt_fault;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sts_ff <= '0;
            msk_ff <= '0;
            rdata_ff <= '0;
        end
        else
        begin
            sts_ff <= nxt_sts;
            msk_ff <= nxt_msk;
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_busy = (op_ff == OP_BUSY);
    assign o_flash_write = (op_ff == OP_BUSY) && !op_erase_ff;
    assign o_flash_erase = (op_ff == OP_BUSY) && op_erase_ff;
    assign o_irq = |(sts_ff & msk_ff);

    // helper: cycles since the running operation began
    logic [TMR_W-1:0] run_cnt_ff;
    wire [TMR_W-1:0] nxt_run_cnt = start_go ? '0 : (o_busy ? run_cnt_ff + 1'b1 : run_cnt_ff);

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_cnt_ff <= '0;
        end
        else
        begin
            run_cnt_ff <= nxt_run_cnt;
        end
    end

    chk_unlock_reads_zero: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        i_rd && i_addr == `FPWC_ADDR_UNLOCK |=> o_rdata == '0)
        else $error("Unlock port read returned nonzero");

    chk_erase_select_op: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        start_go && i_wdata[`FPWC_CTL_ERASE] |=> o_flash_erase && !o_flash_write)
        else $error("Start with erase select did not erase");

    chk_write_only_op: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        start_go && !i_wdata[`FPWC_CTL_ERASE] |=> o_flash_write && !o_flash_erase)
        else $error("Start without erase select did not write");

    chk_permit_needed: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        $rose(o_busy) |-> $past(permit_ff))
        else $error("Operation began without program permit");

    chk_fault_on_start: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        start_req |=> fault_ff)
        else $error("Fault flag not set on start");

    chk_start_cleared: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        op_done && !op_erase_ff |-> start_ff && run_cnt_ff == WRITE_LEN - 1'b1 ##1 !start_ff && !fault_ff)
        else $error("Start bit not cleared at write completion");

    chk_fault_hold: assert property (
        @(posedge i_clk_sys) disable iff (!i_npor)
        fault_ff && !op_done |=> fault_ff)
        else $error("Fault flag dropped without completion");

    chk_refused_idle: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        start_req && !permit_ff && !o_busy |=> !o_busy && !start_ff [*2])
        else $error("Start without permit began an operation");
endmodule // fpwc_top
`default_nettype wire

// file: dv/fpwc_top_tb.sv
// Self-checking testbench for the flash program write control block
`timescale 1ns/10ps
`default_nettype none
`include "fpwc_defines.svh"
module fpwc_top_tb;
    // Shortened operation times keep the run brief
    localparam int WR_NS = 200;
    localparam int ER_NS = 800;
    localparam int WCYC = WR_NS / `FPWC_CLK_PERIOD_NS;
    localparam int ECYC = ER_NS / `FPWC_CLK_PERIOD_NS;
    logic i_clk_sys;
    logic i_nrst;
    logic i_npor;
    logic [`FPWC_ADDR_W-1:0] i_addr;
    logic [`FPWC_DATA_W-1:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [`FPWC_DATA_W-1:0] o_rdata;
    logic o_flash_write;
    logic o_flash_erase;
    logic o_busy;
    logic o_irq;
    int fail_count;
    int tests_run;
    int busy_cyc;
    logic [7:0] rv;

    fpwc_top #(
        .WRITE_TIME_NS(WR_NS),
        .ERASE_TIME_NS(ER_NS),
        .TMR_W(`FPWC_TMR_W)
    ) u_fpwc_top (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_npor(i_npor),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .o_flash_write(o_flash_write),
        .o_flash_erase(o_flash_erase),
        .o_busy(o_busy),
        .o_irq(o_irq)
    );

    always #10 i_clk_sys = ~i_clk_sys;

    always @(posedge i_clk_sys)
    begin
        if (o_busy === 1'b1)
            busy_cyc <= busy_cyc + 1;
    end

    function automatic logic [7:0] ctl_val(logic s, logic p, logic f, logic e);
        return {3'h0, e, f, p, s, 1'b0};
    endfunction

    task automatic results();
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus(logic w, logic r, logic [1:0] a, logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr <= w;
        i_rd <= r;
        i_addr <= a;
        i_wdata <= d;
    endtask

    task automatic wr(logic [1:0] a, logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    task automatic rchk(logic [1:0] a, logic [7:0] exp, string name);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        #1;
        chk(name, exp, o_rdata);
    endtask

    // Unlock sequence, control write, then one edge so the write lands
    task automatic start(logic [7:0] d);
        wr(`FPWC_ADDR_UNLOCK, `FPWC_UNLOCK_KEY1);
        wr(`FPWC_ADDR_UNLOCK, `FPWC_UNLOCK_KEY2);
        wr(`FPWC_ADDR_CTL, d);
        bus(1'b0, 1'b0, `FPWC_ADDR_CTL, 8'h00);
        #1;
    endtask

    task automatic wait_idle();
        int k;
        for (k = 0; k < 300 && o_busy !== 1'b0; k++)
            @(posedge i_clk_sys);
        if (k == 300)
        begin
            fail_count++;
            $display("BAD busy expected 0 seen %b", o_busy);
            results();
        end
        #1;
    endtask

    initial
    begin
        i_clk_sys = 1'b0;
        i_nrst = 1'b0;
        i_npor = 1'b0;
        i_addr = '0;
        i_wdata = '0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        fail_count = 0;
        tests_run = 0;
        busy_cyc = 0;
        rv = 8'($urandom(74));
        repeat (12) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        i_npor <= 1'b1;
        rchk(`FPWC_ADDR_CTL, ctl_val(0, 0, 0, 0), "ctl_por");
        rchk(`FPWC_ADDR_STS, 8'h00, "sts_por");
        rchk(`FPWC_ADDR_MSK, 8'h00, "msk_por");
        for (int i = 0; i < 4; i++)
        begin
            rv = 8'($urandom);
            wr(`FPWC_ADDR_UNLOCK, rv);
            rchk(`FPWC_ADDR_UNLOCK, 8'h00, "unlock_rd");
        end
        // Start with permit clear is refused and flagged
        start(8'h02);
        chk("busy_refused", 8'h00, {7'h0, o_busy});
        chk("write_refused", 8'h00, {7'h0, o_flash_write});
        rchk(`FPWC_ADDR_CTL, ctl_val(0, 0, 1, 0), "ctl_refused");
        rchk(`FPWC_ADDR_STS, 8'h02, "sts_refused");
        wr(`FPWC_ADDR_CTL, 8'h04);
        rchk(`FPWC_ADDR_CTL, ctl_val(0, 1, 1, 0), "ctl_permit");
        // Write operation, with an attempt to clear start mid-run
        busy_cyc = 0;
        start(8'h06);
        chk("write_on", 8'h01, {7'h0, o_flash_write});
        chk("erase_off", 8'h00, {7'h0, o_flash_erase});
        rchk(`FPWC_ADDR_CTL, ctl_val(1, 1, 1, 0), "ctl_busy");
        wr(`FPWC_ADDR_CTL, 8'h04);
        rchk(`FPWC_ADDR_CTL, ctl_val(1, 1, 1, 0), "start_held");
        wait_idle();
        chk("write_len", WCYC[7:0], busy_cyc[7:0]);
        rchk(`FPWC_ADDR_CTL, ctl_val(0, 1, 0, 0), "ctl_done");
        rchk(`FPWC_ADDR_STS, 8'h03, "sts_done");
        // Erase operation
        busy_cyc = 0;
        start(8'h16);
        chk("erase_on", 8'h01, {7'h0, o_flash_erase});
        chk("write_off", 8'h00, {7'h0, o_flash_write});
        wait_idle();
        chk("erase_len", ECYC[7:0], busy_cyc[7:0]);
        rchk(`FPWC_ADDR_CTL, ctl_val(0, 1, 0, 1), "ctl_erased");
        // Interrupt: random mask, then clear status bits one by one
        rv = 8'($urandom);
        wr(`FPWC_ADDR_MSK, rv);
        rchk(`FPWC_ADDR_MSK, rv & 8'h03, "msk_rw");
        chk("irq_rnd", {7'h0, |(rv[1:0])}, {7'h0, o_irq});
        wr(`FPWC_ADDR_MSK, 8'h03);
        wr(`FPWC_ADDR_STS, 8'h01);
        rchk(`FPWC_ADDR_STS, 8'h02, "sts_w1c");
        chk("irq_left", 8'h01, {7'h0, o_irq});
        wr(`FPWC_ADDR_STS, 8'h02);
        rchk(`FPWC_ADDR_STS, 8'h00, "sts_clr");
        chk("irq_clr", 8'h00, {7'h0, o_irq});
        wr(`FPWC_ADDR_MSK, 8'h00);
        // Plain reset cuts a write; the fault flag must survive it
        start(8'h06);
        repeat (3) @(posedge i_clk_sys);
        i_nrst <= 1'b0;
        @(posedge i_clk_sys);
        #1;
        chk("busy_rst", 8'h00, {7'h0, o_busy});
        @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        rchk(`FPWC_ADDR_CTL, ctl_val(0, 0, 1, 0), "ctl_cut");
        @(posedge i_clk_sys);
        i_npor <= 1'b0;
        @(posedge i_clk_sys);
        i_npor <= 1'b1;
        rchk(`FPWC_ADDR_CTL, ctl_val(0, 0, 0, 0), "ctl_por2");
        results();
    end
endmodule // fpwc_top_tb
`default_nettype wire
